// >>> shared/chan_cfg.svh
// constants for the expansion channel cycle controller
// assumes a 200 mhz sys_clk; channel clock is an enable derived from it
`ifndef CHAN_CFG_SVH
`define CHAN_CFG_SVH
`define SYS_CLK_NS        5
`define CHAN_CLK_NS       210
`define CHAN_DIV          (`CHAN_CLK_NS / `SYS_CLK_NS)
`define MEM_CLKS          4
`define IO_CLKS           5
`define DMA_CLKS          5
`define REF_CLKS          4
`define REF_PERIOD        72
`define RDY_MAX_CLKS      10
`define NMI_GATE_ADDR     8'ha0
`define NMI_GATE_MASK     8'hf0
`define NMI_EN_BIT        7
`define NMI_GATE_RST      1'b0
`define IO_CARD_LO        10'h100
`define IO_CARD_HI        10'h3ff
`endif

// >>> shared/chan_pkg.sv
// types for the expansion channel cycle controller
// assumes nothing beyond the cfg header
package chan_pkg;
    typedef enum logic [1:0] {CYC_MEM, CYC_IO, CYC_DMA, CYC_REF} cyc_kind_t;
    typedef enum {ST_IDLE, ST_RUN, ST_WAIT} cyc_state_t;
endpackage

// >>> shared/chan_tick_if.sv
// carries the channel clock enable between the divider and the controller
// assumes a single sys_clk domain
`timescale 1ns/10ps
`default_nettype none
interface chan_tick_if;
    logic tick;
    modport src (output tick);
    modport dst (input  tick);
endinterface
`default_nettype wire

// >>> hdl/chan_tick_div.sv
// divides sys_clk into the 210 ns channel clock enable
// assumes sys_clk at 200 mhz
`timescale 1ns/10ps
`default_nettype none
`include "chan_cfg.svh"
module chan_tick_div #(
    parameter int DIV = `CHAN_DIV
) (
    input  wire logic   sys_clk,
    input  wire logic   rst,
    chan_tick_if.src    tk
);
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;

    always_comb begin
        if (cnt_q == 8'(DIV - 1))
            cnt_d = 8'h00;
        else
            cnt_d = cnt_q + 8'h01;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst)
            cnt_q <= 8'h00;
        else
            cnt_q <= cnt_d;
    end

    assign tk.tick = (cnt_q == 8'(DIV - 1));
endmodule
`default_nettype wire

// >>> hdl/chan_cycle_ctrl.sv
// expansion channel cycle controller: cycle lengths, ready stretch,
// refresh pacing, channel check to nmi with a write-only gate
// assumes requests from same-clock logic; card pins are asynchronous
//
// Contract
// R01: processor memory cycles last four channel clocks without wait
// R02: processor i/o cycles last five channel clocks without wait
// R03: each dma transfer lasts five channel clocks without wait
// R04: refresh issued every 72 channel clocks, each taking four clocks
// R05: cycles stretch only while an addressed card holds ready low
// R06: channel check from any card raises nmi, subject to the gate
// R07: memory cards report parity errors on the channel check line
// R08: after power-on the nmi path stays blocked until software enables
// R09: write 80 hex to a0 enables nmi, 00 hex disables it
// R10: 768 i/o addresses are left to cards, rest for system board
// R11: 8-bit data, 20 address lines, six irq and three dma channels
// R12: last-slot card drives its select response whenever addressed
// R13: overlapping sync and bisync address blocks never installed together
// R14: cards never hold ready low beyond ten channel clocks
// R15: stretch in whole channel clock periods only
// R16: channel check line is active low
// R17: while dma grant is high cards ignore processor i/o cycles
// R18: gate answers any i/o write a0 to af, using data bit 7
// R19: system reset returns the gate to blocked
`timescale 1ns/10ps
`default_nettype none
`include "chan_cfg.svh"
module chan_cycle_ctrl #(
    parameter int REF_PERIOD = `REF_PERIOD
) (
    input  wire logic               sys_clk,
    input  wire logic               rst,
    input  wire logic               cyc_req,
    input  wire chan_pkg::cyc_kind_t cyc_kind,
    input  wire logic               cyc_write,
    input  wire logic [19:0]        cyc_addr,  // [R11]
    input  wire logic [7:0]         cyc_wdata, // [R11]
    output logic                    cyc_busy,
    output logic                    cyc_done,
    output logic                    ref_active,
    output logic                    dma_bus_grant,
    output logic                    card_space,
    input  wire logic               channel_ready_line,
    input  wire logic               channel_error_line_n,
    input  wire logic               slot_select_response_n,
    output logic                    last_slot_steer,
    output logic                    nmi_req,
    output logic                    nmi_enabled
);
    default clocking chk_cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    chan_tick_if tk ();

    chan_tick_div u_div (
        .sys_clk (sys_clk),
        .rst     (rst),
        .tk      (tk)
    );

    // two-stage synchronisers for card pins
    logic rdy_s1_q, rdy_s2_q, chk_s1_q, chk_s2_q, sel_s1_q, sel_s2_q;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rdy_s1_q <= 1'b1;
            rdy_s2_q <= 1'b1;
            chk_s1_q <= 1'b1;
            chk_s2_q <= 1'b1;
            sel_s1_q <= 1'b1;
            sel_s2_q <= 1'b1;
        end else begin
            rdy_s1_q <= channel_ready_line;
            rdy_s2_q <= rdy_s1_q;
            chk_s1_q <= channel_error_line_n;
            chk_s2_q <= chk_s1_q;
            sel_s1_q <= slot_select_response_n;
            sel_s2_q <= sel_s1_q;
        end
    end

    function automatic logic [3:0] nominal(input chan_pkg::cyc_kind_t k);
        unique case (k)
            chan_pkg::CYC_MEM: nominal = 4'(`MEM_CLKS);  // [R01]
            chan_pkg::CYC_IO:  nominal = 4'(`IO_CLKS);   // [R02]
            chan_pkg::CYC_DMA: nominal = 4'(`DMA_CLKS);  // [R03]
            chan_pkg::CYC_REF: nominal = 4'(`REF_CLKS);  // [R04]
        endcase
    endfunction

    chan_pkg::cyc_state_t st_q, st_d;
    chan_pkg::cyc_kind_t  kind_q, kind_d;
    logic [3:0]  clk_q, clk_d;
    logic [6:0]  ref_cnt_q, ref_cnt_d;
    logic        ref_pend_q, ref_pend_d;
    logic        wr_q, wr_d;
    logic [19:0] addr_q, addr_d;
    logic [7:0]  wdata_q, wdata_d;
    logic        done_q, done_d;
    logic        gate_q, gate_d;
    logic        nmi_q, nmi_d;
    logic        steer_q, steer_d;
    logic        gate_hit;

    always_comb begin
        st_d       = st_q;
        kind_d     = kind_q;
        clk_d      = clk_q;
        ref_cnt_d  = ref_cnt_q;
        ref_pend_d = ref_pend_q;
        wr_d       = wr_q;
        addr_d     = addr_q;
        wdata_d    = wdata_q;
        done_d     = 1'b0;
        if (tk.tick) begin
            if (ref_cnt_q == 7'(REF_PERIOD - 1)) begin
                ref_cnt_d  = 7'h00;
                ref_pend_d = 1'b1;                       // [R04]
            end else begin
                ref_cnt_d = ref_cnt_q + 7'h01;
            end
        end
        unique case (st_q)
            chan_pkg::ST_IDLE: begin
                if (tk.tick && (ref_pend_q || ref_pend_d)) begin
                    st_d       = chan_pkg::ST_RUN;
                    kind_d     = chan_pkg::CYC_REF;
                    ref_pend_d = 1'b0;
                    clk_d      = 4'h1;
                end else if (tk.tick && cyc_req) begin
                    st_d    = chan_pkg::ST_RUN;
                    kind_d  = cyc_kind;
                    wr_d    = cyc_write;
                    addr_d  = cyc_addr;
                    wdata_d = cyc_wdata;
                    clk_d   = 4'h1;
                end
            end
            chan_pkg::ST_RUN, chan_pkg::ST_WAIT: begin
                if (tk.tick) begin
                    // wait only in the last nominal clock, whole clocks
                    if (clk_q >= nominal(kind_q) && !rdy_s2_q
                        && kind_q != chan_pkg::CYC_REF) begin
                        st_d = chan_pkg::ST_WAIT;        // [R05] [R15]
                    end else if (clk_q >= nominal(kind_q)) begin
                        st_d   = chan_pkg::ST_IDLE;
                        done_d = 1'b1;
                    end else begin
                        st_d  = chan_pkg::ST_RUN;
                        clk_d = clk_q + 4'h1;
                    end
                end
            end
        endcase
    end

    // any i/o write a0..af by the processor hits the gate
    assign gate_hit = done_d && kind_q == chan_pkg::CYC_IO && wr_q &&
        (addr_q[7:0] & `NMI_GATE_MASK) == `NMI_GATE_ADDR &&
        addr_q[9:8] == 2'b00;                            // [R18]

    always_comb begin
        gate_d  = gate_hit ? wdata_q[`NMI_EN_BIT] : gate_q;  // [R09] [R18]
        nmi_d   = gate_q && !chk_s2_q;                   // [R06] [R16]
        steer_d = !sel_s2_q && st_q != chan_pkg::ST_IDLE;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_q       <= chan_pkg::ST_IDLE;
            kind_q     <= chan_pkg::CYC_MEM;
            clk_q      <= 4'h0;
            ref_cnt_q  <= 7'h00;
            ref_pend_q <= 1'b0;
            wr_q       <= 1'b0;
            addr_q     <= 20'h00000;
            wdata_q    <= 8'h00;
            done_q     <= 1'b0;
            gate_q     <= `NMI_GATE_RST;                 // [R08] [R19]
            nmi_q      <= 1'b0;
            steer_q    <= 1'b0;
        end else begin
            st_q       <= st_d;
            kind_q     <= kind_d;
            clk_q      <= clk_d;
            ref_cnt_q  <= ref_cnt_d;
            ref_pend_q <= ref_pend_d;
            wr_q       <= wr_d;
            addr_q     <= addr_d;
            wdata_q    <= wdata_d;
            done_q     <= done_d;
            gate_q     <= gate_d;
            nmi_q      <= nmi_d;
            steer_q    <= steer_d;
        end
    end

    assign cyc_busy        = st_q != chan_pkg::ST_IDLE;
    assign cyc_done        = done_q;
    assign ref_active      = cyc_busy && kind_q == chan_pkg::CYC_REF;
    assign dma_bus_grant   = cyc_busy && (kind_q == chan_pkg::CYC_DMA ||
                             kind_q == chan_pkg::CYC_REF);       // [R17]
    assign card_space      = addr_q[9:0] >= `IO_CARD_LO;         // [R10]
    assign last_slot_steer = steer_q;                            // [R12]
    assign nmi_req         = nmi_q;
    assign nmi_enabled     = gate_q;

    // nmi blocked from the cycle after the gate is closed
    a_nmi_gated: assert property (!gate_q |=> !nmi_q) // [R08]
        else $error("nmi while gate closed");
    a_nmi_raise: assert property (gate_q && !chk_s2_q |=> nmi_q) // [R06]
        else $error("nmi missed");
    a_gate_write: assert property ( // [R09]
        gate_hit |=> gate_q == $past(wdata_q[`NMI_EN_BIT]))
        else $error("gate not written");
    a_wait_ready: assert property ( // [R05]
        st_q == chan_pkg::ST_WAIT && $past(st_q) != chan_pkg::ST_WAIT
        |-> !$past(rdy_s2_q)) else $error("stretch without not-ready");
    a_ref_kind: assert property ( // [R04]
        ref_active |-> st_q != chan_pkg::ST_WAIT)
        else $error("refresh stretched");
    a_done_tick: assert property (done_q |-> $past(tk.tick)) // [R15]
        else $error("end off clock");
    a_mem_len: assert property ( // [R01]
        done_d && kind_q == chan_pkg::CYC_MEM |-> clk_q == 4'h4)
        else $error("memory cycle length");
    a_io_len: assert property ( // [R02] [R03]
        done_d && kind_q != chan_pkg::CYC_MEM && kind_q != chan_pkg::CYC_REF
        |-> clk_q == 4'h5) else $error("io or dma cycle length");
endmodule
`default_nettype wire

// >>> bench/card_model.sv
// adapter card model sitting in the last expansion slot
// assumes busy from the controller and the bench's request address mark the card's cycle
`timescale 1ns/10ps
`default_nettype none
module card_model (
    input  wire logic        sys_clk,
    input  wire logic        cyc_busy,
    input  wire logic        ref_active,
    input  wire logic [19:0] cyc_addr,
    input  wire logic [19:0] card_base,
    input  wire logic [11:0] hold_clks,
    input  wire logic        err_req,
    output logic             channel_ready_line,
    output logic             channel_error_line_n,
    output logic             slot_select_response_n
);
    logic [11:0] cnt_q;
    logic        hit;
    // one decoded block per card, never overlapping another card
    assign hit = cyc_busy && !ref_active && cyc_addr[19:4] == card_base[19:4];
    always_ff @(posedge sys_clk) begin
        cnt_q <= hit ? cnt_q + 12'h001 : 12'h000;
    end
    // released lines return to the pull-up level
    assign channel_ready_line = !(hit && cnt_q < hold_clks);
    assign slot_select_response_n = !hit;
    assign channel_error_line_n = !err_req;
endmodule
`default_nettype wire

// >>> bench/testbench.sv
// self-checking bench for the channel cycle controller
// assumes one card model in the last slot, sys_clk at 200 mhz
`timescale 1ns/10ps
`default_nettype none
module testbench;
    localparam int T  = 42;
    localparam int RP = 8;
    localparam chan_pkg::cyc_kind_t M = chan_pkg::CYC_MEM;
    localparam chan_pkg::cyc_kind_t I = chan_pkg::CYC_IO;
    localparam chan_pkg::cyc_kind_t D = chan_pkg::CYC_DMA;
    typedef struct {
        chan_pkg::cyc_kind_t k;
        logic w;
        logic [19:0] a;
        logic [7:0] d;
        int e;
        logic sl;
        logic sp;
        logic en;
    } row_t;
    row_t rows [12] = '{
        '{M, 0, 20'h00000, 8'h00, 0, 0, 0, 0},
        '{M, 1, 20'h00100, 8'h80, 0, 0, 1, 0},
        '{I, 1, 20'h000a0, 8'h80, 0, 0, 0, 1},
        '{I, 1, 20'h000a7, 8'h7f, 0, 0, 0, 0},
        '{I, 1, 20'h000af, 8'h80, 0, 0, 0, 1},
        '{M, 1, 20'h000a0, 8'h00, 0, 0, 0, 1},
        '{I, 1, 20'h000b0, 8'h00, 0, 0, 0, 1},
        '{I, 1, 20'h000a0, 8'h00, 0, 0, 0, 0},
        '{D, 0, 20'h00300, 8'h00, 0, 1, 1, 0},
        '{I, 0, 20'h00305, 8'h00, 3, 1, 1, 0},
        '{M, 0, 20'h00310, 8'h00, 2, 0, 1, 0},
        '{M, 0, 20'h0030f, 8'h00, 2, 1, 1, 0}};
    logic                sys_clk, rst, cyc_req, cyc_write, err_req;
    chan_pkg::cyc_kind_t cyc_kind;
    logic [19:0]         cyc_addr;
    logic [7:0]          cyc_wdata;
    logic [11:0]         hold_clks;
    logic                cyc_busy, cyc_done, ref_active, dma_bus_grant;
    logic                card_space, last_slot_steer, nmi_req, nmi_enabled;
    logic                channel_ready_line, channel_error_line_n;
    logic                slot_select_response_n;
    int                  mismatches = 0;
    int                  tests_run = 0;
    int                  n;
    chan_cycle_ctrl #(.REF_PERIOD(RP)) chan_cycle_ctrl_inst (.sys_clk, .rst,
        .cyc_req, .cyc_kind, .cyc_write, .cyc_addr, .cyc_wdata, .cyc_busy,
        .cyc_done, .ref_active, .dma_bus_grant, .card_space,
        .channel_ready_line, .channel_error_line_n, .slot_select_response_n,
        .last_slot_steer, .nmi_req, .nmi_enabled);
    card_model card_model_inst (.sys_clk, .cyc_busy, .ref_active, .cyc_addr,
        .card_base(20'h00300), .hold_clks, .err_req, .channel_ready_line,
        .channel_error_line_n, .slot_select_response_n);
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    task automatic chk_bit(input string s, input logic x, input logic g);
        tests_run++;
        if (g !== x) begin
            mismatches++;
            $display("mismatch %s expected %b seen %b", s, x, g);
        end
    endtask
    task automatic chk_int(input string s, input int x, input int g);
        tests_run++;
        if (g != x) begin
            mismatches++;
            $display("mismatch %s expected %0d seen %0d", s, x, g);
        end
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic hold_ref(input logic lvl);
        while (ref_active === lvl && n < 900) begin
            @(negedge sys_clk);
            n++;
        end
    endtask
    task automatic run_cyc(input row_t r);
        int g;
        int nom;
        g = 0;
        n = 0;
        nom = (r.k == M) ? 4 : 5;
        cyc_kind = r.k;
        cyc_write = r.w;
        cyc_addr = r.a;
        cyc_wdata = r.d;
        hold_clks = (r.e == 0) ? 12'h000 : 12'((nom + r.e) * T - 21);
        cyc_req = 1'b1;
        while (!(cyc_busy === 1'b1 && ref_active === 1'b0) && g < 900) begin
            @(negedge sys_clk);
            g++;
        end
        cyc_req = 1'b0;
        chk_bit("dma grant", r.k == D, dma_bus_grant);
        while (cyc_busy === 1'b1 && n < 900) begin
            @(negedge sys_clk);
            n++;
        end
        chk_int("cycle clocks", (nom + (r.sl ? r.e : 0)) * T, n);
        chk_bit("done pulse", 1'b1, cyc_done);
    endtask
    initial begin
        #200000;
        mismatches++;
        wrap_up();
    end
    initial begin
        {rst, cyc_req, cyc_write, err_req} = 4'h8;
        cyc_kind = M;
        cyc_addr = 20'h00000;
        cyc_wdata = 8'h00;
        hold_clks = 12'h000;
        repeat (16) @(negedge sys_clk);
        rst = 1'b0;
        chk_bit("gate", 1'b0, nmi_enabled);
        for (int i = 0; i < 12; i++) begin
            run_cyc(rows[i]);
            chk_bit("card space", rows[i].sp, card_space);
            chk_bit("slot steer", rows[i].sl, last_slot_steer);
            chk_bit("gate", rows[i].en, nmi_enabled);
            $display("row %0d done", i);
        end
        err_req = 1'b1;
        repeat (6) @(negedge sys_clk);
        chk_bit("nmi masked", 1'b0, nmi_req);
        run_cyc('{I, 1, 20'h000a0, 8'h80, 0, 0, 0, 1});
        repeat (4) @(negedge sys_clk);
        chk_bit("nmi raised", 1'b1, nmi_req);
        err_req = 1'b0;
        repeat (6) @(negedge sys_clk);
        chk_bit("nmi idle", 1'b0, nmi_req);
        err_req = 1'b1;
        rst = 1'b1;
        repeat (2) @(negedge sys_clk);
        rst = 1'b0;
        repeat (6) @(negedge sys_clk);
        chk_bit("gate", 1'b0, nmi_enabled);
        chk_bit("nmi after reset", 1'b0, nmi_req);
        err_req = 1'b0;
        $display("nmi and reset test done");
        n = 0;
        hold_ref(1'b0);
        chk_bit("refresh grant", 1'b1, dma_bus_grant);
        n = 0;
        hold_ref(1'b1);
        chk_int("refresh clocks", 4 * T, n);
        hold_ref(1'b0);
        chk_int("refresh period", RP * T, n);
        $display("refresh test done");
        wrap_up();
    end
endmodule
`default_nettype wire
